// ### common/nsp_pkg.sv
// Package of constants, types and helpers for the flash section protection
package nsp_pkg;

  localparam int              FLASH_AW      = 17;
  localparam int              LIM_W         = 18;
  localparam logic [LIM_W-1:0] FLASH_BYTES  = 18'h20000;
  localparam logic [FLASH_AW-1:0] FLASH_FIRST = 17'h00000;
  localparam logic [3:0]      PAGE_SHIFT    = 4'h9;
  localparam logic [2:0]      MAX_ERASE_EXP = 3'h5;
  localparam logic [FLASH_AW-1:0] EE_SIZE   = 17'h00200;
  localparam logic [FLASH_AW-1:0] USER_SIZE = 17'h00020;
  localparam logic [FLASH_AW-1:0] SIG_SIZE  = 17'h00080;
  localparam logic [FLASH_AW-1:0] FUSE_SIZE = 17'h00010;
  localparam logic [7:0]      LOADER_FUSE_DEF  = 8'h00;
  localparam logic [7:0]      PROGRAM_FUSE_DEF = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_FUSE   = 8'h08;
  localparam logic [7:0] ADR_LLIM   = 8'h0C;
  localparam logic [7:0] ADR_PLIM   = 8'h10;
  localparam int BIT_RGUARD = 0;
  localparam int BIT_PGUARD = 1;
  localparam int BIT_DGUARD = 2;
  localparam int BIT_VSEL   = 3;
  localparam int BIT_BUSY   = 0;
  localparam int BIT_DENY   = 1;
  localparam int BIT_READY  = 2;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    OP_READ, OP_FETCH, OP_WRITE, OP_ERASE, OP_ERWR
  } nsp_op_type;
  typedef enum logic [2:0] {
    SP_FLASH, SP_EEPROM, SP_SIGROW, SP_USER, SP_FUSE
  } nsp_space_type;
  typedef enum logic [1:0] {RG_LOADER, RG_PROGRAM, RG_PARAM} nsp_region_type;
  typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_BUSY} nsp_state_type;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [LIM_W-1:0] nsp_blk_bytes(input logic [7:0] f);
    return LIM_W'(f) << PAGE_SHIFT;
  endfunction

  function automatic nsp_region_type nsp_region_of(
      input logic [FLASH_AW-1:0] a,
      input logic [LIM_W-1:0]    ll,
      input logic [LIM_W-1:0]    pl);
    if ({1'b0, a} < ll) return RG_LOADER;
    if ({1'b0, a} < pl) return RG_PROGRAM;
    return RG_PARAM;
  endfunction

  // Clears the address bits below the erase block size
  function automatic logic [FLASH_AW-1:0] nsp_align(
      input logic [FLASH_AW-1:0] a,
      input logic [3:0]          lsb);
    logic [FLASH_AW-1:0] r;
    r = a;
    for (int i = 0; i < FLASH_AW; i++) begin
      if (i < int'(lsb)) r[i] = 1'b0;
    end
    return r;
  endfunction

endpackage

// ### hdl/nsp_region_map.sv
// Flash region limits derived from the two size fuses
`timescale 1ns/1ps
`default_nettype none
module nsp_region_map
  import nsp_pkg::*;
(
  input  wire logic [7:0]       loader_size_fuse,
  input  wire logic [7:0]       program_size_fuse,
  output logic      [LIM_W-1:0] loader_limit,
  output logic      [LIM_W-1:0] program_limit
);
  logic [7:0] lf;
  logic [7:0] pf;

  always_comb begin
    lf = (nsp_blk_bytes(loader_size_fuse) > FLASH_BYTES) ?
         LOADER_FUSE_DEF : loader_size_fuse;
    pf = (nsp_blk_bytes(program_size_fuse) > FLASH_BYTES) ?
         PROGRAM_FUSE_DEF : program_size_fuse;
    loader_limit  = nsp_blk_bytes(lf);
    program_limit = nsp_blk_bytes(pf);
    if (lf == 8'h00) begin
      loader_limit  = FLASH_BYTES;
      program_limit = FLASH_BYTES;
    end else if (pf == 8'h00) begin
      program_limit = FLASH_BYTES;
    end else if (pf <= lf) begin
      program_limit = loader_limit;
    end
  end
endmodule
`default_nettype wire

// ### hdl/nsp_access_check.sv
// Permission decision for one access to the nonvolatile spaces
`timescale 1ns/1ps
`default_nettype none
module nsp_access_check
  import nsp_pkg::*;
(
  input  wire logic                from_dbg,
  input  wire nsp_op_type          op,
  input  wire nsp_space_type       space,
  input  wire logic [FLASH_AW-1:0] addr,
  input  wire logic                word,
  input  wire logic [2:0]          erase_exp,
  input  wire nsp_region_type      exec_region,
  input  wire nsp_region_type      target_region,
  input  wire logic                read_guard,
  input  wire logic                program_guard,
  input  wire logic                param_guard,
  input  wire logic                dbg_locked,
  output logic                     allow
);
  logic self_ok;
  logic guard_ok;
  logic exp_ok;
  logic rd;

  always_comb begin
    rd = (op == OP_READ);
    exp_ok = (erase_exp <= MAX_ERASE_EXP);
    self_ok = from_dbg ||
      (exec_region == RG_LOADER && target_region != RG_LOADER) ||
      (exec_region == RG_PROGRAM && target_region == RG_PARAM);
    guard_ok = !(target_region == RG_PROGRAM && program_guard) &&
               !(target_region == RG_PARAM && param_guard);
    allow = 1'b0;
    unique case (space)
      SP_FLASH: begin
        if (rd || op == OP_FETCH) begin
          allow = from_dbg || !(read_guard && target_region == RG_LOADER &&
                  exec_region != RG_LOADER);
        end else if (op == OP_WRITE) begin
          allow = self_ok && guard_ok;
        end else if (op == OP_ERASE) begin
          allow = self_ok && guard_ok && exp_ok;
        end
      end
      SP_EEPROM: begin
        // Code in the parameter region may not program the EEPROM
        allow = (addr < EE_SIZE) && (rd || ((from_dbg ||
                exec_region != RG_PARAM) &&
                (((op == OP_WRITE || op == OP_ERWR) && !word) ||
                (op == OP_ERASE && exp_ok))));
      end
      SP_SIGROW: allow = rd && (addr < SIG_SIZE);
      SP_USER: begin
        allow = (addr < USER_SIZE) &&
                ((rd && !(from_dbg && dbg_locked)) ||
                (op == OP_WRITE && !word) || op == OP_ERASE);
      end
      SP_FUSE: begin
        allow = (addr < FUSE_SIZE) && !word &&
                (rd || (from_dbg && (op == OP_WRITE ||
                op == OP_ERASE || op == OP_ERWR)));
      end
      default: allow = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ### hdl/nsp_top.sv
// Nonvolatile memory section protection with Wishbone control registers
//
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module nsp_top
  import nsp_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic                cpu_req,
  input  wire nsp_op_type          cpu_op,
  input  wire nsp_space_type       cpu_space,
  input  wire logic [FLASH_AW-1:0] cpu_addr,
  input  wire logic [15:0]         cpu_wdata,
  input  wire logic                cpu_word,
  input  wire logic [2:0]          cpu_erase_exp,
  input  wire logic [FLASH_AW-1:0] cpu_pc,
  output logic                     cpu_stall,
  output logic                     cpu_done,
  output logic                     cpu_denied,
  output logic      [15:0]         cpu_rdata,
  input  wire logic                dbg_req,
  input  wire nsp_op_type          dbg_op,
  input  wire nsp_space_type       dbg_space,
  input  wire logic [FLASH_AW-1:0] dbg_addr,
  input  wire logic [15:0]         dbg_wdata,
  input  wire logic                dbg_word,
  input  wire logic [2:0]          dbg_erase_exp,
  input  wire logic                dbg_locked,
  output logic                     dbg_done,
  output logic                     dbg_denied,
  output logic      [15:0]         dbg_rdata,
  output logic                     mem_req,
  output nsp_op_type               mem_op,
  output nsp_space_type            mem_space,
  output logic      [FLASH_AW-1:0] mem_addr,
  output logic      [15:0]         mem_wdata,
  output logic                     mem_word,
  output logic      [2:0]          mem_erase_exp,
  input  wire logic                mem_ack,
  input  wire logic [15:0]         mem_rdata,
  input  wire logic [7:0]          fuse_loader_val,
  input  wire logic [7:0]          fuse_program_val,
  output logic      [7:0]          cfg_loader_size,
  output logic      [7:0]          cfg_program_size,
  output logic      [LIM_W-1:0]    vec_base_addr
);

  typedef struct packed {
    nsp_state_type       st;
    logic                rguard;
    logic                pguard;
    logic                dguard;
    logic                vsel;
    logic                deny_flag;
    logic [7:0]          lfuse;
    logic [7:0]          pfuse;
    logic                src_dbg;
    nsp_region_type      ex_rg;
    logic                mem_req;
    nsp_op_type          mem_op;
    nsp_space_type       mem_space;
    logic [FLASH_AW-1:0] mem_addr;
    logic [15:0]         mem_wdata;
    logic                mem_word;
    logic [2:0]          mem_exp;
    logic                cpu_done;
    logic                cpu_deny;
    logic                dbg_done;
    logic                dbg_deny;
    logic [15:0]         rdata;
    logic                wb_ack;
    logic [31:0]         wb_dat;
  } nsp_regs_type;

  nsp_regs_type        s_reg;
  nsp_regs_type        s_next;
  logic [LIM_W-1:0]    ll;
  logic [LIM_W-1:0]    pl;
  nsp_region_type      ex_rg;
  nsp_region_type      tg_rg;
  logic                sel_dbg;
  logic                sel_cpu;
  logic                take;
  logic                allow;
  nsp_op_type          r_op;
  nsp_space_type       r_space;
  logic [FLASH_AW-1:0] r_addr;
  logic [15:0]         r_wdata;
  logic                r_word;
  logic [2:0]          r_exp;
  logic [FLASH_AW-1:0] r_mem_addr;
  logic                wb_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Limits follow the copied fuses, not the live fuse array
  nsp_region_map u_map (
    .loader_size_fuse  (s_reg.lfuse),
    .program_size_fuse (s_reg.pfuse),
    .loader_limit      (ll),
    .program_limit     (pl)
  );

  // Debug port wins; a source just answered is skipped for one cycle
  always_comb begin
    sel_dbg = dbg_req && !(s_reg.dbg_done || s_reg.dbg_deny);
    sel_cpu = cpu_req && !(s_reg.cpu_done || s_reg.cpu_deny);
    take    = (s_reg.st == ST_IDLE) && (sel_dbg || sel_cpu);
    r_op    = sel_dbg ? dbg_op        : cpu_op;
    r_space = sel_dbg ? dbg_space     : cpu_space;
    r_addr  = sel_dbg ? dbg_addr      : cpu_addr;
    r_wdata = sel_dbg ? dbg_wdata     : cpu_wdata;
    r_word  = sel_dbg ? dbg_word      : cpu_word;
    r_exp   = sel_dbg ? dbg_erase_exp : cpu_erase_exp;
    ex_rg   = nsp_region_of(cpu_pc, ll, pl);
    tg_rg   = nsp_region_of(r_addr, ll, pl);
    r_mem_addr = r_addr;
    if (r_op == OP_ERASE) begin
      unique case (r_space)
        SP_FLASH:  r_mem_addr = nsp_align(r_addr,
                                PAGE_SHIFT + {1'b0, r_exp});
        SP_EEPROM: r_mem_addr = nsp_align(r_addr, {1'b0, r_exp});
        SP_USER:   r_mem_addr = '0;
        default:   r_mem_addr = r_addr;
      endcase
    end
  end

  nsp_access_check u_check (
    .from_dbg      (sel_dbg),
    .op            (r_op),
    .space         (r_space),
    .addr          (r_addr),
    .word          (r_word),
    .erase_exp     (r_exp),
    .exec_region   (ex_rg),
    .target_region (tg_rg),
    .read_guard    (s_reg.rguard),
    .program_guard (s_reg.pguard),
    .param_guard   (s_reg.dguard),
    .dbg_locked    (dbg_locked),
    .allow         (allow)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Writes commit on the edge where the master sees ack
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && s_reg.wb_ack &&
                 wb_sel_i[0];

  always_comb begin
    s_next = s_reg;
    s_next.cpu_done = 1'b0;
    s_next.cpu_deny = 1'b0;
    s_next.dbg_done = 1'b0;
    s_next.dbg_deny = 1'b0;
    s_next.wb_ack   = wb_cyc_i && wb_stb_i && !s_reg.wb_ack;
    if (s_next.wb_ack) begin
      s_next.wb_dat = '0;
      unique case (wb_adr_i)
        ADR_CTRL: begin
          s_next.wb_dat[BIT_RGUARD] = s_reg.rguard;
          s_next.wb_dat[BIT_PGUARD] = s_reg.pguard;
          s_next.wb_dat[BIT_DGUARD] = s_reg.dguard;
          s_next.wb_dat[BIT_VSEL]   = s_reg.vsel;
        end
        ADR_STATUS: begin
          s_next.wb_dat[BIT_BUSY]  = (s_reg.st == ST_BUSY);
          s_next.wb_dat[BIT_DENY]  = s_reg.deny_flag;
          s_next.wb_dat[BIT_READY] = (s_reg.st != ST_INIT);
        end
        ADR_FUSE: s_next.wb_dat[15:0] = {s_reg.pfuse, s_reg.lfuse};
        ADR_LLIM: s_next.wb_dat[LIM_W-1:0] = ll;
        ADR_PLIM: s_next.wb_dat[LIM_W-1:0] = pl;
        default:  s_next.wb_dat = '0;
      endcase
    end
    if (wb_wr && wb_adr_i == ADR_CTRL) begin
      // Guards only set; clearing waits for reset
      if (ex_rg == RG_LOADER) begin
        s_next.rguard = s_reg.rguard | wb_dat_i[BIT_RGUARD];
      end
      s_next.pguard = s_reg.pguard | wb_dat_i[BIT_PGUARD];
      s_next.dguard = s_reg.dguard | wb_dat_i[BIT_DGUARD];
      s_next.vsel   = wb_dat_i[BIT_VSEL];
    end
    if (wb_wr && wb_adr_i == ADR_STATUS && wb_dat_i[BIT_DENY]) begin
      s_next.deny_flag = 1'b0;
    end
    unique case (s_reg.st)
      ST_INIT: begin
        s_next.lfuse = fuse_loader_val;
        s_next.pfuse = fuse_program_val;
        s_next.st    = ST_IDLE;
      end
      ST_IDLE: begin
        if (take && allow) begin
          s_next.mem_req   = 1'b1;
          s_next.src_dbg   = sel_dbg;
          s_next.ex_rg     = ex_rg;
          s_next.mem_op    = r_op;
          s_next.mem_space = r_space;
          s_next.mem_addr  = r_mem_addr;
          s_next.mem_wdata = r_wdata;
          s_next.mem_word  = r_word;
          s_next.mem_exp   = r_exp;
          s_next.st        = ST_BUSY;
        end else if (take) begin
          // Denial set wins over a same-cycle software clear
          s_next.dbg_deny  = sel_dbg;
          s_next.cpu_deny  = !sel_dbg;
          s_next.deny_flag = 1'b1;
        end
      end
      ST_BUSY: begin
        if (mem_ack) begin
          s_next.mem_req  = 1'b0;
          s_next.rdata    = mem_rdata;
          s_next.dbg_done = s_reg.src_dbg;
          s_next.cpu_done = !s_reg.src_dbg;
          s_next.st       = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CPU waits until answered, so a flash erase holds it throughout
  assign cpu_stall = cpu_req && !(s_reg.cpu_done || s_reg.cpu_deny);
  assign cpu_done         = s_reg.cpu_done;
  assign cpu_denied       = s_reg.cpu_deny;
  assign cpu_rdata        = s_reg.rdata;
  assign dbg_done         = s_reg.dbg_done;
  assign dbg_denied       = s_reg.dbg_deny;
  assign dbg_rdata        = s_reg.rdata;
  assign mem_req          = s_reg.mem_req;
  assign mem_op           = s_reg.mem_op;
  assign mem_space        = s_reg.mem_space;
  assign mem_addr         = s_reg.mem_addr;
  assign mem_wdata        = s_reg.mem_wdata;
  assign mem_word         = s_reg.mem_word;
  assign mem_erase_exp    = s_reg.mem_exp;
  assign wb_ack_o         = s_reg.wb_ack;
  assign wb_dat_o         = s_reg.wb_dat;
  assign cfg_loader_size  = s_reg.lfuse;
  assign cfg_program_size = s_reg.pfuse;
  assign vec_base_addr = s_reg.vsel ? {1'b0, FLASH_FIRST} : ll;

  ////////////////////////////////////////////////////////////////////////////
  nsp_region_type mem_rg;
  assign mem_rg = nsp_region_of(s_reg.mem_addr, ll, pl);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  deny_no_array_a: assert property (
    (s_reg.st == ST_IDLE && take && !allow) |=>
      (s_reg.cpu_deny || s_reg.dbg_deny) && !s_reg.mem_req)
    else $error("denied access reached the array");

  erase_stall_a: assert property (
    (s_reg.mem_req && !s_reg.src_dbg && s_reg.mem_op == OP_ERASE &&
     cpu_req) |-> cpu_stall)
    else $error("cpu not stalled during erase");

  page_align_a: assert property (
    (s_reg.mem_req && s_reg.mem_space == SP_FLASH &&
     s_reg.mem_op == OP_ERASE) |-> s_reg.mem_addr[8:0] == 9'h000)
    else $error("flash erase not page aligned");

  sigrow_read_a: assert property (
    (s_reg.mem_req && s_reg.mem_space == SP_SIGROW) |->
      s_reg.mem_op == OP_READ)
    else $error("signature row modified");

  fuse_dbg_only_a: assert property (
    (s_reg.mem_req && s_reg.mem_space == SP_FUSE &&
     s_reg.mem_op != OP_READ) |-> s_reg.src_dbg)
    else $error("cpu programmed a fuse");

  self_region_a: assert property (
    $rose(s_reg.mem_req) && !s_reg.src_dbg &&
    s_reg.mem_space == SP_FLASH &&
    (s_reg.mem_op == OP_WRITE || s_reg.mem_op == OP_ERASE) |->
      mem_rg != s_reg.ex_rg && !(mem_rg == RG_PROGRAM &&
      s_reg.ex_rg != RG_LOADER))
    else $error("self-programming of own region");

  write_guard_a: assert property (
    $rose(s_reg.mem_req) && s_reg.mem_space == SP_FLASH &&
    s_reg.mem_op != OP_READ && s_reg.mem_op != OP_FETCH |->
      !($past(s_reg.pguard) && mem_rg == RG_PROGRAM) &&
      !($past(s_reg.dguard) && mem_rg == RG_PARAM))
    else $error("guarded region updated");

  fuse_copy_a: assert property (
    (s_reg.st == ST_INIT) |=> cfg_loader_size == $past(fuse_loader_val) &&
      cfg_program_size == $past(fuse_program_val) && s_reg.st == ST_IDLE)
    else $error("fuses not copied at start-up");

  vec_table_a: assert property (
    vec_base_addr == (s_reg.vsel ? '0 : ll))
    else $error("vector table base wrong");

  user_locked_a: assert property (
    $rose(s_reg.mem_req) && s_reg.src_dbg && s_reg.mem_space == SP_USER &&
    s_reg.mem_op == OP_READ |-> !$past(dbg_locked))
    else $error("locked user row read by debug");

  ee_byte_a: assert property (
    (s_reg.mem_req && s_reg.mem_space == SP_EEPROM &&
     s_reg.mem_op != OP_READ) |-> !s_reg.mem_word &&
     s_reg.mem_exp <= MAX_ERASE_EXP)
    else $error("eeprom word write or oversized erase");

  whole_loader_a: assert property (
    (s_reg.st != ST_INIT && s_reg.lfuse == 8'h00) |->
      ll == FLASH_BYTES && pl == FLASH_BYTES)
    else $error("zero loader fuse not whole flash");

  wb_ack_drop_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  erase_done_c: cover property (
    s_reg.mem_req && s_reg.mem_op == OP_ERASE ##[1:20] cpu_done);
  deny_c: cover property (cpu_denied);
  dbg_fuse_c: cover property (
    s_reg.mem_req && s_reg.src_dbg && s_reg.mem_space == SP_FUSE);

endmodule
`default_nettype wire

// ### bench/nsp_mem_model.sv
// Array model answering the block's memory requests
`timescale 1ns/1ps
`default_nettype none
module nsp_mem_model
  import nsp_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                mem_req,
  input  wire logic [FLASH_AW-1:0] mem_addr,
  input  wire logic [3:0]          lat,
  output logic                     mem_ack,
  output logic      [15:0]         mem_rdata
);
  logic [3:0] cnt = 4'h0;
  initial mem_ack = 1'b0;
  initial mem_rdata = 16'h0000;
  // Read data flips every idle cycle so stale data never looks valid
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      cnt <= cnt + 4'h1;
      if (cnt >= lat) begin
        mem_ack <= 1'b1;
        mem_rdata <= mem_addr[15:0] ^ 16'h5A5A;
        cnt <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/test_nvm_section_protection.sv
// Self-checking bench for the flash section protection block
`timescale 1ns/1ps
`default_nettype none
module test_nvm_section_protection;
  import nsp_pkg::*;
  logic clk, arst_n, wreq, wb_we_i, wb_ack_o, cpu_req, cpu_stall, cpu_done;
  logic cpu_denied, dbg_req, dbg_locked, dbg_done, dbg_denied, mem_req;
  logic mem_word, mem_ack, seen, st;
  logic [7:0] wb_adr_i, fuse_loader_val, fuse_program_val;
  logic [7:0] cfg_loader_size, cfg_program_size;
  logic [31:0] wb_dat_i, wb_dat_o, r;
  logic [15:0] cpu_rdata, dbg_rdata, mem_wdata, mem_rdata;
  logic [16:0] cpu_addr, cpu_pc, mem_addr, ma;
  logic [2:0] cpu_erase_exp, mem_erase_exp;
  logic [3:0] lat;
  logic [17:0] vec_base_addr;
  nsp_op_type cpu_op, mem_op;
  nsp_space_type cpu_space, mem_space;
  int num_errors = 0;
  int check_count = 0;
  nsp_top i_dut (.wb_cyc_i(wreq), .wb_stb_i(wreq), .wb_sel_i(4'hF),
    .cpu_wdata(16'h00A5), .cpu_word(1'b0), .dbg_op(cpu_op),
    .dbg_space(cpu_space), .dbg_addr(cpu_addr), .dbg_wdata(16'h00A5),
    .dbg_word(1'b0), .dbg_erase_exp(cpu_erase_exp), .*);
  nsp_mem_model i_mem (.clk(clk), .mem_req(mem_req), .mem_addr(mem_addr),
    .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (mem_req) begin
    ma <= mem_addr;
    st <= cpu_stall;
    seen <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rst(input logic [7:0] lf, input logic [7:0] pf);
    @(posedge clk);
    arst_n <= 1'b0;
    fuse_loader_val <= lf;
    fuse_program_val <= pf;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // Holds the request until ack; cyc then drops for one cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    wreq <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk); while (!wb_ack_o && ++n < 50);
    r = wb_dat_o;
    wreq <= 1'b0;
    @(posedge clk);
  endtask
  // Access from cpu (d=0) or debug port (d=1); ok says granted
  task automatic acc(input logic d, input nsp_op_type o,
                     input nsp_space_type s, input logic [16:0] a,
                     input logic ok);
    int n = 0;
    logic dn, dd;
    @(posedge clk);
    seen = 1'b0;
    cpu_req <= !d;
    dbg_req <= d;
    cpu_op <= o;
    cpu_space <= s;
    cpu_addr <= a;
    do begin
      @(posedge clk);
      dn = d ? dbg_done : cpu_done;
      dd = d ? dbg_denied : cpu_denied;
    end while (!(dn || dd) && ++n < 100);
    r = {16'h0000, d ? dbg_rdata : cpu_rdata};
    cpu_req <= 1'b0;
    dbg_req <= 1'b0;
    chk(dn ? 32'h1 : dd ? 32'h0 : 32'hBAD, {31'h0, ok});
    chk({31'h0, seen}, {31'h0, ok});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {arst_n, wreq, wb_we_i, cpu_req, dbg_req, dbg_locked} = '0;
    {wb_adr_i, wb_dat_i, cpu_addr, cpu_erase_exp, lat} = '0;
    {cpu_op, cpu_space, seen, st, ma} = '0;
    cpu_pc = 17'h00100;
    rst(8'h04, 8'h08);
    chk(cfg_loader_size, 32'h4);
    chk(cfg_program_size, 32'h8);
    wb(0, ADR_LLIM, 0); chk(r, 32'h800);
    wb(0, ADR_PLIM, 0); chk(r, 32'h1000);
    chk(vec_base_addr, 32'h800);
    wb(1, ADR_CTRL, 32'h8); chk(vec_base_addr, 32'h0);
    acc(0, OP_WRITE, SP_FLASH, 17'h00900, 1);
    acc(0, OP_WRITE, SP_FLASH, 17'h00200, 0);
    cpu_pc <= 17'h00900;
    acc(0, OP_WRITE, SP_FLASH, 17'h00900, 0);
    acc(0, OP_WRITE, SP_FLASH, 17'h01200, 1);
    cpu_pc <= 17'h01100;
    acc(0, OP_WRITE, SP_FLASH, 17'h01200, 0);
    acc(0, OP_WRITE, SP_FLASH, 17'h00900, 0);
    acc(0, OP_READ, SP_SIGROW, 17'h10, 1); chk(r, 32'h5A4A);
    acc(0, OP_WRITE, SP_SIGROW, 17'h10, 0);
    acc(1, OP_ERASE, SP_SIGROW, 17'h0, 0);
    acc(0, OP_WRITE, SP_FUSE, 17'h0, 0);
    acc(1, OP_WRITE, SP_FUSE, 17'h0, 1);
    acc(0, OP_READ, SP_FUSE, 17'h1, 1);
    dbg_locked <= 1'b1;
    acc(1, OP_READ, SP_USER, 17'h3, 0);
    acc(1, OP_WRITE, SP_USER, 17'h3, 1);
    dbg_locked <= 1'b0;
    acc(1, OP_READ, SP_USER, 17'h3, 1);
    acc(0, OP_WRITE, SP_USER, 17'h1F, 1);
    cpu_pc <= 17'h00100;
    for (int e = 0; e < 6; e++) begin
      cpu_erase_exp <= e[2:0];
      acc(0, OP_ERASE, SP_EEPROM, 17'h1F, 1);
      chk(ma, 17'h1F & ~((17'h1 << e) - 17'h1));
    end
    acc(0, OP_ERWR, SP_EEPROM, 17'h1FF, 1);
    lat <= 4'h5;
    cpu_erase_exp <= 3'h2;
    acc(0, OP_ERASE, SP_FLASH, 17'h01A34, 1);
    chk(ma, 32'h1800);
    chk(st, 32'h1);
    chk(mem_erase_exp, 32'h2);
    chk(mem_op, OP_ERASE);
    wb(1, ADR_CTRL, 32'hA);
    acc(1, OP_WRITE, SP_FLASH, 17'h00900, 0);
    wb(1, ADR_CTRL, 32'hE);
    acc(0, OP_WRITE, SP_FLASH, 17'h01200, 0);
    wb(1, ADR_CTRL, 32'hF);
    acc(0, OP_READ, SP_FLASH, 17'h10, 1);
    cpu_pc <= 17'h01100;
    acc(0, OP_READ, SP_FLASH, 17'h10, 0);
    acc(0, OP_FETCH, SP_FLASH, 17'h12, 0);
    rst(8'h00, 8'h00);
    wb(0, ADR_LLIM, 0); chk(r, 32'h20000);
    rst(8'h04, 8'h00);
    wb(0, ADR_PLIM, 0); chk(r, 32'h20000);
    rst(8'h08, 8'h04);
    acc(0, OP_WRITE, SP_FLASH, 17'h01400, 0);
    wb(0, ADR_STATUS, 0); chk(r, 32'h6);
    cpu_pc <= 17'h00100;
    acc(0, OP_WRITE, SP_FLASH, 17'h01400, 1);
    conclude();
  end
  // Whole run needs well under 20 us
  initial begin
    #200000;
    num_errors++;
    conclude();
  end
endmodule
`default_nettype wire
